// >>> ime_i2c_master.sv
/*
 * two-wire master byte engine with an apb register port.
 * each transmit-data write to an enabled, idle engine launches one bus action: start plus
 * address, data byte out, data byte in, or stop.
 * assumes apb signals synchronous to CLK_SYS_I, sda and scl pads
 * resolved outside from the output enables, and prescale >= 2.
 */
//
// Summary of operation
// - master only, never answers as slave
// - seven-bit address, bytes shifted msb first
// - scl equals clock over prescale plus one, halved
// - prescaler reaches 100 and 400 kbit/s
// - sda only pulled low or released
// - done flag set when ready for action
// - start plus enable, then address write starts
// - transmit write clears the done flag
// - after byte out, done set, ack recorded
// - plain transmit write sends a data byte
// - stop plus enable, dummy write ends transfer
// - start again with read bit gives repeated start
// - dummy write in read mode clocks byte in
// - received byte sets ready flag, readable
// - single read byte gets not-acknowledge
// - read address start goes straight to data
// - ack-out set acks bytes, cleared for last
// - any number of data bytes before stop
`timescale 1ns/1ps

module ime_i2c_master (
    input wire logic CLK_SYS_I, // system clock, 50 MHz
    input wire logic RST_N_I, // async reset, active low
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb direction, high = write
    input wire logic [ime_pkg::IME_ADDR_W-1:0] PADDR_I, // apb byte address
    input wire logic [31:0] PWDATA_I, // apb write data
    output logic [31:0] PRDATA_O, // apb read data
    output logic PREADY_O, // apb ready
    output logic PSLVERR_O, // apb error, unmapped address
    output logic SCL_O, // scl output level, always low
    output logic SCL_OE_O, // scl pull low while high
    input wire logic SDA_I, // sda pad level
    output logic SDA_O, // sda output level, always low
    output logic SDA_OE_O // sda pull low while high
);
    import ime_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic pready_q; // access phase answered
    logic [31:0] prdata_q; // registered read data
    logic pslverr_q; // registered error
    logic acc_end; // access phase completes this edge
    logic wr_en; // write takes effect
    logic rd_en; // read takes effect
    logic mapped; // address hits a register
    logic [31:0] rd_mux; // read data selection
    logic [IME_PRESCALE_W-1:0] prescale_q; // clock_divider_value
    logic start_request_q; // start request pending
    logic stop_request_q; // stop request pending
    logic master_ack_enable_q; // ack received bytes
    logic interface_enable_q; // interface enable
    logic op_done_flag_q; // ready for new action
    logic slave_ack_seen_q; // slave acked last byte
    logic rx_byte_ready_q; // received byte waiting
    logic [7:0] rx_data_q; // last received byte
    logic tx_wr; // transmit-data write strobe
    logic launch; // action accepted by engine
    ime_state_e state_q; // engine state
    logic [1:0] sub_q; // step within a state
    logic [2:0] bit_q; // bit index within byte
    logic [7:0] shift_q; // shift register, msb on the wire
    logic byte_rx_q; // current byte is received
    logic read_mode_q; // address had read bit set
    logic fin_q; // one-cycle action complete
    logic [IME_PRESCALE_W-1:0] div_q; // half-period counter
    logic tick; // end of half period
    logic scl_pull_d; // next scl pull state
    logic scl_oe_q; // scl pulled low
    logic sda_oe_q; // sda pulled low
    logic sda_out_q; // constant low output level

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // one wait state: ready rises on the second access cycle
    assign acc_end = PSEL_I && PENABLE_I && pready_q;
    assign wr_en = acc_end && PWRITE_I && mapped;
    assign rd_en = acc_end && !PWRITE_I && mapped;
    assign tx_wr = wr_en && (PADDR_I == IME_OFS_TXDATA);

    // address decode
    always_comb begin
        mapped = 1'b0;
        rd_mux = 32'h0000_0000;
        unique case (PADDR_I)
            IME_OFS_PRESCALE: begin
                mapped = 1'b1;
                rd_mux = {16'h0000, prescale_q};
            end
            IME_OFS_CTRL: begin
                mapped = 1'b1;
                rd_mux = {28'h000_0000, interface_enable_q, master_ack_enable_q,
                          stop_request_q, start_request_q};
            end
            IME_OFS_STATUS: begin
                mapped = 1'b1;
                rd_mux = {28'h000_0000, (state_q != ST_IDLE), rx_byte_ready_q,
                          slave_ack_seen_q, op_done_flag_q};
            end
            IME_OFS_TXDATA: begin
                mapped = 1'b1; // reads as zero
            end
            IME_OFS_RXDATA: begin
                mapped = 1'b1;
                rd_mux = {24'h00_0000, rx_data_q};
            end
            default: begin
                mapped = 1'b0; // unmapped
            end
        endcase
    end

    // ready, read data and error registered
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= PSEL_I && PENABLE_I && !pready_q;
            if (PSEL_I && PENABLE_I && !pready_q) begin
                prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_mux;
                pslverr_q <= !mapped;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler and control registers
    // ------------------------------------------------------------
    // prescaler value written by software
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prescale_q <= IME_PRESCALE_RST;
        end else if (wr_en && PADDR_I == IME_OFS_PRESCALE) begin
            prescale_q <= PWDATA_I[IME_PRESCALE_W-1:0];
        end
    end

    // control bits; requests consumed by the launch they steer
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {interface_enable_q, master_ack_enable_q, stop_request_q, start_request_q} <= IME_CTRL_RST;
        end else if (wr_en && PADDR_I == IME_OFS_CTRL) begin
            start_request_q <= PWDATA_I[IME_CTRL_START];
            stop_request_q <= PWDATA_I[IME_CTRL_STOP];
            master_ack_enable_q <= PWDATA_I[IME_CTRL_ACKOUT];
            interface_enable_q <= PWDATA_I[IME_CTRL_ENABLE];
        end else if (launch) begin
            start_request_q <= 1'b0;
            stop_request_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // done: cleared by transmit write, completion wins
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            op_done_flag_q <= IME_DONE_RST;
        end else if (fin_q) begin
            op_done_flag_q <= 1'b1;
        end else if (tx_wr) begin
            op_done_flag_q <= 1'b0;
        end
    end

    // slave acknowledge sampled on the ninth clock of a byte out
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            slave_ack_seen_q <= 1'b0;
        end else if (tick && state_q == ST_ACK && sub_q == 2'h1 && !byte_rx_q) begin
            slave_ack_seen_q <= !SDA_I;
        end
    end

    // received byte and its ready flag; new byte wins over read clear
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_byte_ready_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else if (tick && state_q == ST_ACK && sub_q == 2'h1 && byte_rx_q) begin
            rx_byte_ready_q <= 1'b1;
            rx_data_q <= shift_q;
        end else if (rd_en && PADDR_I == IME_OFS_RXDATA) begin
            rx_byte_ready_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // half-period timer
    // ------------------------------------------------------------
    // tick every prescale+1 clocks; one scl level per tick
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_q <= '0;
        end else if (state_q == ST_IDLE || div_q == prescale_q) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = (state_q != ST_IDLE) && (div_q == prescale_q);

    // ------------------------------------------------------------
    // engine sequencing
    // ------------------------------------------------------------
    assign launch = tx_wr && (state_q == ST_IDLE) && interface_enable_q;

    // action selection and step sequencing
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            sub_q <= 2'h0;
            bit_q <= IME_BIT_MSB;
            shift_q <= 8'h00;
            byte_rx_q <= 1'b0;
            read_mode_q <= 1'b0;
            fin_q <= 1'b0;
        end else begin
            fin_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    sub_q <= 2'h0;
                    bit_q <= IME_BIT_MSB;
                    if (tx_wr && !interface_enable_q) begin
                        fin_q <= 1'b1; // disabled: nothing sent, ready again
                    end else if (launch && start_request_q) begin
                        state_q <= ST_START;
                        shift_q <= PWDATA_I[7:0];
                        byte_rx_q <= 1'b0;
                        read_mode_q <= PWDATA_I[0];
                    end else if (launch && stop_request_q) begin
                        state_q <= ST_STOP;
                    end else if (launch) begin
                        state_q <= ST_BIT;
                        shift_q <= PWDATA_I[7:0];
                        byte_rx_q <= read_mode_q;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        sub_q <= sub_q + 2'h1;
                        if (sub_q == IME_SUB_LAST_START) begin
                            state_q <= ST_BIT;
                            sub_q <= 2'h0;
                        end
                    end
                end
                ST_BIT: begin
                    if (tick) begin
                        if (sub_q == 2'h0) begin
                            sub_q <= 2'h1;
                        end else begin
                            sub_q <= 2'h0;
                            shift_q <= {shift_q[6:0], SDA_I};
                            bit_q <= bit_q - 3'h1;
                            if (bit_q == 3'h0) begin
                                state_q <= ST_ACK;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (tick) begin
                        sub_q <= sub_q + 2'h1;
                        if (sub_q == 2'h2) begin
                            state_q <= ST_IDLE; // bus held, scl low
                            fin_q <= 1'b1;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        sub_q <= sub_q + 2'h1;
                        if ((sub_q == 2'h0 && !scl_oe_q) || sub_q == 2'h2) begin
                            state_q <= ST_IDLE; // bus released
                            fin_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // scl level per step
    // ------------------------------------------------------------
    // scl follows the step one clock after it is entered
    always_comb begin
        scl_pull_d = scl_oe_q;
        unique case (state_q)
            ST_IDLE: scl_pull_d = scl_oe_q;
            ST_START: scl_pull_d = (sub_q == 2'h0) ? scl_oe_q : (sub_q == IME_SUB_LAST_START);
            ST_BIT: scl_pull_d = (sub_q == 2'h0);
            ST_ACK: scl_pull_d = (sub_q != 2'h1);
            ST_STOP: scl_pull_d = (sub_q == 2'h0) ? scl_oe_q : 1'b0;
            default: scl_pull_d = 1'b0;
        endcase
    end

    // scl driver; master only, never stretched or released to a slave
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= scl_pull_d;
        end
    end

    // ------------------------------------------------------------
    // sda driver
    // ------------------------------------------------------------
    // data moves only once scl is seen low, conditions only with it high
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_START: begin
                    if (sub_q == 2'h0 && scl_oe_q) begin
                        sda_oe_q <= 1'b0; // release before restart
                    end else if (sub_q == 2'h2 && !scl_oe_q) begin
                        sda_oe_q <= 1'b1;
                    end
                end
                ST_BIT: begin
                    if (sub_q == 2'h0 && scl_oe_q) begin
                        sda_oe_q <= !byte_rx_q && !shift_q[7];
                    end
                end
                ST_ACK: begin
                    if (sub_q == 2'h0 && scl_oe_q) begin
                        sda_oe_q <= byte_rx_q && master_ack_enable_q;
                    end else if (sub_q == 2'h2 && scl_oe_q) begin
                        sda_oe_q <= 1'b0;
                    end
                end
                ST_STOP: begin
                    if (sub_q == 2'h0 && scl_oe_q) begin
                        sda_oe_q <= 1'b1;
                    end else if (sub_q == 2'h2 && !scl_oe_q) begin
                        sda_oe_q <= 1'b0; // stop, bus free
                    end
                end
                default: begin
                    sda_oe_q <= sda_oe_q; // idle holds the line
                end
            endcase
        end
    end

    // open-drain output level is always low
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign SCL_O = sda_out_q;
    assign SCL_OE_O = scl_oe_q;
    assign SDA_O = sda_out_q;
    assign SDA_OE_O = sda_oe_q;

endmodule

// >>> ime_pkg.sv
/*
 * constants for the two-wire master byte engine: register offsets,
 * field positions, reset values and the engine state type.
 * assumes a 32-bit apb slave port with byte addresses on paddr.
 */
package ime_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int unsigned IME_ADDR_W = 8; // apb address width
    localparam logic [7:0] IME_OFS_PRESCALE = 8'h00; // clock prescaler
    localparam logic [7:0] IME_OFS_CTRL = 8'h04; // control
    localparam logic [7:0] IME_OFS_STATUS = 8'h08; // status
    localparam logic [7:0] IME_OFS_TXDATA = 8'h0C; // transmit data
    localparam logic [7:0] IME_OFS_RXDATA = 8'h10; // receive data

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned IME_PRESCALE_W = 16; // clock_divider_value width
    localparam int unsigned IME_CTRL_START = 0; // start_request
    localparam int unsigned IME_CTRL_STOP = 1; // stop_request
    localparam int unsigned IME_CTRL_ACKOUT = 2; // master_ack_enable
    localparam int unsigned IME_CTRL_ENABLE = 3; // interface_enable
    localparam int unsigned IME_STAT_DONE = 0; // op_done_flag
    localparam int unsigned IME_STAT_ACKIN = 1; // slave_ack_seen
    localparam int unsigned IME_STAT_RXRDY = 2; // rx_byte_ready
    localparam int unsigned IME_STAT_BUSY = 3; // engine busy

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // 50 MHz / (249 + 1) / 2 = 100 kHz
    localparam logic [15:0] IME_PRESCALE_RST = 16'h00F9; // prescaler after reset
    localparam logic [3:0] IME_CTRL_RST = 4'h0; // control after reset
    localparam logic IME_DONE_RST = 1'b1; // ready after reset
    localparam logic [2:0] IME_BIT_MSB = 3'h7; // first bit index of a byte
    localparam logic [1:0] IME_SUB_LAST_START = 2'h3; // last start step

    // ------------------------------------------------------------
    // engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,  // waiting for a transmit write
        ST_START, // start or repeated start
        ST_BIT,   // one data bit, send or receive
        ST_ACK,   // ninth clock
        ST_STOP   // stop condition
    } ime_state_e;

endpackage

// >>> ime_i2c_master_assertions.sv
/* checker for the byte engine: apb timing and two-wire pin timing.
   assumes it is bound to ime_i2c_master and that prescale stays >= 2. */
`timescale 1ns/1ps
module ime_i2c_master_chk (
    input wire logic CLK_SYS_I, // clock
    input wire logic RST_N_I, // reset, low
    input wire logic PSEL_I, // select
    input wire logic PENABLE_I, // enable
    input wire logic PWRITE_I, // direction
    input wire logic [ime_pkg::IME_ADDR_W-1:0] PADDR_I, // address
    input wire logic [31:0] PWDATA_I, // write data
    input wire logic [31:0] PRDATA_O, // read data
    input wire logic PREADY_O, // ready
    input wire logic PSLVERR_O, // error
    input wire logic SCL_O, // scl level
    input wire logic SCL_OE_O, // scl pull
    input wire logic SDA_I, // sda wire
    input wire logic SDA_O, // sda level
    input wire logic SDA_OE_O // sda pull
);
    import ime_pkg::*;
    logic [16:0] hi_q; // cycles with scl released
    logic mv_q, oe_q; // sda moved in high phase, last sda pull
    logic [15:0] pre_q; // prescale copy
    logic [3:0] ctl_q; // control copy
    logic wr_ok, tx_wr; // completed write, transmit write
    assign wr_ok = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
    assign tx_wr = wr_ok && PADDR_I == IME_OFS_TXDATA;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // ----------------------------------------
    // shadow of prescale, control and scl phase
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hi_q <= 17'h0;
            mv_q <= 1'b0;
            oe_q <= 1'b0;
            pre_q <= IME_PRESCALE_RST;
            ctl_q <= IME_CTRL_RST;
        end else begin
            oe_q <= SDA_OE_O;
            hi_q <= SCL_OE_O ? 17'h0 : hi_q + 17'h1;
            mv_q <= !SCL_OE_O && (mv_q || SDA_OE_O != oe_q);
            if (wr_ok && PADDR_I == IME_OFS_PRESCALE) pre_q <= PWDATA_I[15:0];
            if (wr_ok && PADDR_I == IME_OFS_CTRL) ctl_q <= PWDATA_I[3:0];
            else if (tx_wr) ctl_q <= ctl_q & 4'hC; // launch consumes start and stop
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_apb_wait; PSEL_I && !PENABLE_I |=> !PREADY_O ##1 PREADY_O; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("ready not on second access cycle");
    property p_slverr; PSLVERR_O |-> PREADY_O && (PWRITE_I || PRDATA_O == 32'h0); endproperty
    a_slverr: assert property (p_slverr) else $error("error without ready or with data");
    property p_pull_only; !SDA_O && !SCL_O; endproperty
    a_pull_only: assert property (p_pull_only) else $error("pin driven high");
    property p_apart; $changed(SDA_OE_O) |-> $stable(SCL_OE_O); endproperty
    a_apart: assert property (p_apart) else $error("sda and scl moved together");
    property p_cond_hold; $changed(SDA_OE_O) && !SCL_OE_O |=> !SCL_OE_O [*2]; endproperty
    a_cond_hold: assert property (p_cond_hold) else $error("scl fell right after condition");
    property p_scl_high; $rose(SCL_OE_O) && !mv_q |-> hi_q == {1'b0, pre_q} + 17'h1; endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high half has wrong length");
    property p_start; tx_wr && ctl_q[0] && ctl_q[3] |-> ##[1:1000] SDA_OE_O && !SCL_OE_O; endproperty
    a_start: assert property (p_start) else $error("no start condition");
    property p_stop; tx_wr && ctl_q == 4'hA |-> ##[1:1000] !SDA_OE_O && !SCL_OE_O; endproperty
    a_stop: assert property (p_stop) else $error("bus not released after stop");
endmodule
bind ime_i2c_master ime_i2c_master_chk i_chk(.*);

// >>> ime_eeprom_model.sv
/* serial eeprom stand-in: 7-bit address, 256 bytes, pointer auto increment.
   assumes resolved scl and sda wires with pull-ups. */
`timescale 1ns/1ps
module ime_eeprom_model #(parameter logic [6:0] DEV = 7'h50) (
    input wire logic scl_i, // scl wire
    input wire logic sda_i, // sda wire
    output logic pull_o // pulls sda low
);
    logic [7:0] mem [256]; // storage
    logic [7:0] ptr, rx, tx; // pointer, shift in, shift out
    logic act, rd, first, wa, snd, mack; // frame state
    int cnt; // scl rises in this byte
    initial begin
        pull_o = 1'b0;
        act = 1'b0;
        ptr = 8'h0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    end
    // start and stop seen with scl high
    always @(negedge sda_i) if (scl_i) begin
        {act, first, wa, snd, pull_o} = 5'h1C;
        cnt = 0;
    end
    always @(posedge sda_i) if (scl_i) {act, pull_o} = 2'h0;
    // sample on rising scl
    always @(posedge scl_i) if (act) begin
        cnt++;
        if (cnt <= 8) rx = {rx[6:0], sda_i};
        if (cnt == 9) mack = !sda_i;
    end
    // drive only while scl low
    always @(negedge scl_i) if (act) begin
        if (cnt == 8) begin
            pull_o = 1'b0;
            if (first) begin
                {act, rd, first} = {rx[7:1] == DEV, rx[0], 1'b0};
                pull_o = act;
            end else if (!rd) begin
                if (!wa) mem[ptr] = rx;
                ptr = wa ? rx : ptr + 8'h1;
                wa = 1'b0;
                pull_o = 1'b1;
            end
        end else if (cnt == 9) begin
            cnt = 0;
            snd = rd && (!snd || mack);
            tx = mem[ptr];
            if (snd) ptr++;
            pull_o = snd && !tx[7];
        end else if (snd && cnt > 0) pull_o = !tx[7 - cnt];
    end
endmodule

// >>> tb_top.sv
/* bench for the byte engine: apb tasks, eeprom model, queued checks.
   assumes the model at address 0x50 and prescale 2 after setup. */
`timescale 1ns/1ps
module tb_top;
    import ime_pkg::*;
    logic CLK_SYS_I = 1'b0, RST_N_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic [7:0] PADDR_I = 8'h0, wa, d0, d1; // address, word address, data
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, r0, seed = 32'h39; // r0 holds last read
    logic PREADY_O, PSLVERR_O, SCL_O, SCL_OE_O, SDA_I, SDA_O, SDA_OE_O, pull;
    logic [32:0] expq[$]; // expected error bit and data
    logic [31:0] mskq[$]; // bits compared
    int bad_count = 0, checked = 0;
    localparam logic [3:0] EN = 4'h8, GO = 4'h9, HALT = 4'hA, ACK = 4'hC; // control words
    localparam logic [31:0] M_ACK = 32'h2, M_RX = 32'h4; // status bits
    localparam logic [6:0] DEV = 7'h50; // slave address
    always #10 CLK_SYS_I = ~CLK_SYS_I;
    assign SDA_I = !(SDA_OE_O || pull); // open drain with pull-up
    ime_i2c_master i_dut(.*);
    ime_eeprom_model i_eep(.scl_i(!SCL_OE_O), .sda_i(SDA_I), .pull_o(pull));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one apb transfer, result noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x,
                       input logic [31:0] m);
        int n;
        n = 0;
        expq.push_back(x);
        mskq.push_back(m);
        @(posedge CLK_SYS_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_SYS_I) PENABLE_I <= 1'b1;
        do @(posedge CLK_SYS_I); while (PREADY_O !== 1'b1 && ++n < 50);
        r0 = PRDATA_O;
        if (n >= 50) bad_count++;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0, x, m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d, {e, 32'h0}, 32'h0);
    endtask
    // control word, transmit write, done cleared, then poll
    task automatic op(input logic [3:0] c, input logic [7:0] t);
        int n;
        n = 0;
        wr(IME_OFS_CTRL, {28'h0, c}, 1'b0);
        wr(IME_OFS_TXDATA, {24'h0, t}, 1'b0);
        rd(IME_OFS_STATUS, 33'h0, 32'h1);
        do rd(IME_OFS_STATUS, 33'h0, 32'h0); while (r0[0] !== 1'b1 && ++n < 300);
        if (n >= 300) begin
            bad_count++;
            wr(IME_OFS_CTRL, {28'h0, HALT}, 1'b0);
            wr(IME_OFS_TXDATA, 32'h0, 1'b0);
        end
    endtask
    // monitor: oldest note against each completed transfer
    always @(negedge CLK_SYS_I) if (PSEL_I && PENABLE_I && PREADY_O === 1'b1) begin
        checked++;
        if ({PSLVERR_O, PRDATA_O & mskq[0]} !== expq[0]) begin
            bad_count++;
            $display("wrong value reg %h exp %h seen %h", PADDR_I, expq[0], {PSLVERR_O, PRDATA_O & mskq[0]});
        end
        void'(expq.pop_front());
        void'(mskq.pop_front());
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000; // about 20000 cycles, well over ten full runs
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        wa = 8'(xs());
        d0 = 8'(xs());
        d1 = 8'(xs());
        rd(IME_OFS_PRESCALE, {17'h0, IME_PRESCALE_RST}, 32'hFFFF);
        rd(IME_OFS_STATUS, 33'h1, 32'hF);
        rd(8'h14, {1'b1, 32'h0}, 32'hFFFFFFFF);
        wr(8'h14, 32'h0, 1'b1);
        wr(IME_OFS_PRESCALE, 32'h2, 1'b0);
        op(GO, {DEV, 1'b0});
        rd(IME_OFS_CTRL, {29'h0, EN}, 32'hF);
        rd(IME_OFS_STATUS, {1'b0, M_ACK}, M_ACK);
        op(EN, wa);
        op(EN, d0);
        op(EN, d1);
        op(HALT, 8'h0);
        op(GO, {DEV, 1'b0});
        op(EN, wa);
        op(GO | ACK, {DEV, 1'b1});
        op(ACK, 8'h0);
        rd(IME_OFS_STATUS, {1'b0, M_RX}, M_RX);
        rd(IME_OFS_RXDATA, {25'h0, d0}, 32'hFF);
        op(EN, 8'h0);
        rd(IME_OFS_RXDATA, {25'h0, d1}, 32'hFF);
        op(HALT, 8'h0);
        op(GO, {DEV, 1'b1});
        op(EN, 8'h0);
        rd(IME_OFS_RXDATA, {25'h0, (wa + 8'h2) ^ 8'hA5}, 32'hFF);
        op(HALT, 8'h0);
        op(GO, {~DEV, 1'b0});
        rd(IME_OFS_STATUS, 33'h0, M_ACK);
        op(HALT, 8'h0);
        end_of_test();
    end
endmodule
